// File: watchdog_pkg.sv
// constants, register map and carrier types of the watchdog block
package watchdog_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 20;
   localparam int unsigned RST_PULSE_NS    = 320;
   localparam int unsigned RST_PULSE_CYC   = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0]  RST_PULSE_LAST  = 5'(RST_PULSE_CYC - 1);

   localparam logic [7:0] OFS_WDA_BASE   = 8'h00;
   localparam logic [7:0] OFS_WDB_BASE   = 8'h10;
   localparam logic [1:0] SUB_CTRL       = 2'h0;
   localparam logic [1:0] SUB_LOAD       = 2'h1;
   localparam logic [1:0] SUB_WIN        = 2'h2;
   localparam logic [1:0] SUB_SERVICE    = 2'h3;
   localparam logic [7:0] OFS_RCV_CTRL   = 8'h20;
   localparam logic [7:0] OFS_RCV_LOAD   = 8'h24;
   localparam logic [7:0] OFS_RCV_SERV   = 8'h28;
   localparam logic [7:0] OFS_STATUS     = 8'h30;
   localparam logic [7:0] OFS_INT_EN     = 8'h34;
   localparam logic [7:0] OFS_INT_CLR    = 8'h38;
   localparam logic [7:0] OFS_CAUSE      = 8'h3c;

   localparam logic [31:0] WD_LOAD_RST   = 32'hffff_ffff;
   localparam logic [31:0] WD_WIN_RST    = 32'hffff_ffff;
   localparam logic [15:0] RCV_LOAD_RST  = 16'hffff;
   localparam int unsigned ST_W          = 5;
   localparam int unsigned ST_TO_A       = 0;
   localparam int unsigned ST_TO_B       = 1;
   localparam int unsigned ST_TO_RCV     = 2;
   localparam int unsigned ST_EARLY_A    = 3;
   localparam int unsigned ST_EARLY_B    = 4;

   typedef enum logic [1:0] {
      CLK_SCALED_SYS = 2'b00,
      CLK_RTC        = 2'b01,
      CLK_PMC        = 2'b10
   } wd_clk_sel_t;

   // ctrl word: bit0 enable, bit1 window, bits3:2 clock, bits31:16 prescale
   typedef struct packed {
      logic [15:0] presc;
      logic [11:0] rsvd;
      logic [1:0]  sel;
      logic        win;
      logic        en;
   } wd_ctrl_t;
   localparam wd_ctrl_t WD_CTRL_RST = '0;
endpackage

// File: watchdog_top.sv
// two windowed watchdogs and one recovery watchdog behind an apb slave
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps

// Functional notes
// - 32-bit prescaled counters; expiry resets system
// - missed or out-of-window service means timeout
// - per-timer reset-cause flag on windowed expiry
// - per-timer clock: scaled sysclk, rtc, pmc
// - 16-bit recovery counter resets system
// - dedicated reset-cause flag for recovery expiry
// - recovery dog counts ring oscillator only
module watchdog_top
   import watchdog_pkg::*;
(
   input  wire logic        CLK_SYS,    // system clock, 50 MHz
   input  wire logic        RST_N,      // async reset, active low
   input  wire logic        PSEL,       // apb select
   input  wire logic        PENABLE,    // apb access phase
   input  wire logic        PWRITE,     // apb direction
   input  wire logic [7:0]  PADDR,      // apb byte address
   input  wire logic [31:0] PWDATA,     // apb write data
   output logic      [31:0] PRDATA,     // apb read data
   output logic             PREADY,     // apb ready
   output logic             PSLVERR,    // apb error on unmapped address
   input  wire logic        RTC_CLK,    // real-time clock pin
   input  wire logic        PMC_CLK,    // power-management clock pin
   input  wire logic        RING_CLK,   // 8 khz ring oscillator
   output logic             SYS_RESET,  // system reset request, high
   output logic             IRQ         // level interrupt
);

   // pin synchronisers: rtc, pmc, ring
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic [2:0] sync3_reg;
   logic [2:0] lvl_reg;
   logic [2:0] lvl_next;
   logic [2:0] tick;

   // a level counts once stages two and three agree
   // rising edge of the filtered level is one source tick
   assign lvl_next = (sync2_reg == sync3_reg) ? sync3_reg : lvl_reg;
   assign tick     = lvl_next & ~lvl_reg;

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         sync3_reg <= 3'h0;
         lvl_reg   <= 3'h0;
      end
      else
      begin
         sync1_reg <= {RING_CLK, PMC_CLK, RTC_CLK};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         lvl_reg   <= lvl_next;
      end
   end

   // tick of the selected source; code 11 keeps the dog stopped
   function automatic logic src_tick(input logic [1:0] sel, input logic [2:0] t);
      case (sel)
         CLK_SCALED_SYS: src_tick = 1'b1;
         CLK_RTC:        src_tick = t[0];
         CLK_PMC:        src_tick = t[1];
         default:        src_tick = 1'b0;
      endcase
   endfunction

   // apb decode
   logic        pready_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic        setup_done;
   logic        wr_acc;
   logic        in_dog;
   logic        dog_idx;
   logic [1:0]  dog_sub;
   logic        mapped;
   logic [31:0] rd_mux;

   // one wait state: pready follows the first access cycle
   assign setup_done = PSEL & PENABLE & ~pready_reg;
   // writes land at the edge where pready is seen high
   assign wr_acc     = PSEL & PENABLE & pready_reg & PWRITE;
   assign in_dog     = (PADDR[7:5] == 3'h0) & (PADDR[1:0] == 2'h0);
   assign dog_idx    = PADDR[4];
   assign dog_sub    = PADDR[3:2];
   assign mapped     = in_dog | (PADDR == OFS_RCV_CTRL) | (PADDR == OFS_RCV_LOAD)
                     | (PADDR == OFS_RCV_SERV) | (PADDR == OFS_STATUS)
                     | (PADDR == OFS_INT_EN) | (PADDR == OFS_INT_CLR)
                     | (PADDR == OFS_CAUSE);

   // windowed watchdogs
   wd_ctrl_t    ctrl_reg   [2];
   logic [31:0] load_reg   [2];
   logic [31:0] win_reg    [2];
   logic [31:0] cnt_reg    [2];
   logic [15:0] pre_reg    [2];
   logic [1:0]  wd_expire;
   logic [1:0]  wd_early;

   for (genvar g = 0; g < 2; g++)
   begin : g_dog
      logic sel_me;
      logic wr_ctrl;
      logic serv_wr;
      logic in_win;
      logic src;
      logic pre_wrap;
      logic cnt_step;
      logic restart;

      assign sel_me   = in_dog & (dog_idx == 1'(g));
      assign wr_ctrl  = wr_acc & sel_me & (dog_sub == SUB_CTRL);
      assign serv_wr  = wr_acc & sel_me & (dog_sub == SUB_SERVICE) & ctrl_reg[g].en;
      // counter runs down, so service is legal at or below win
      assign in_win   = ~ctrl_reg[g].win | (cnt_reg[g] <= win_reg[g]);
      assign src      = ctrl_reg[g].en & src_tick(ctrl_reg[g].sel, tick);
      assign pre_wrap = src & (pre_reg[g] == ctrl_reg[g].presc);
      assign cnt_step = pre_wrap;
      assign wd_early[g]  = serv_wr & ~in_win;
      assign wd_expire[g] = (cnt_step & (cnt_reg[g] == 32'h0)) | wd_early[g];
      // disabled dogs sit at load, ready for the next enable
      assign restart  = wr_ctrl | serv_wr | wd_expire[g] | ~ctrl_reg[g].en;

      always_ff @(posedge CLK_SYS or negedge RST_N)
      begin
         if (!RST_N)
         begin
            ctrl_reg[g] <= WD_CTRL_RST;
            load_reg[g] <= WD_LOAD_RST;
            win_reg[g]  <= WD_WIN_RST;
            cnt_reg[g]  <= WD_LOAD_RST;
            pre_reg[g]  <= 16'h0;
         end
         else
         begin
            if (wr_ctrl)
               ctrl_reg[g] <= wd_ctrl_t'(PWDATA & 32'hffff_000f);
            if (wr_acc & sel_me & (dog_sub == SUB_LOAD))
               load_reg[g] <= PWDATA;
            if (wr_acc & sel_me & (dog_sub == SUB_WIN))
               win_reg[g] <= PWDATA;
            if (restart)
            begin
               cnt_reg[g] <= load_reg[g];
               pre_reg[g] <= 16'h0;
            end
            else if (src)
            begin
               pre_reg[g] <= pre_wrap ? 16'h0 : pre_reg[g] + 16'h1;
               if (cnt_step)
                  cnt_reg[g] <= cnt_reg[g] - 32'h1;
            end
         end
      end
   end

   // recovery watchdog
   logic        rcv_en_reg;
   logic [15:0] rcv_load_reg;
   logic [15:0] rcv_cnt_reg;
   logic        rcv_serv;
   logic        rcv_expire;
   logic        rcv_restart;

   // no window here: any enabled service restarts the count
   assign rcv_serv    = wr_acc & (PADDR == OFS_RCV_SERV) & rcv_en_reg;
   assign rcv_expire  = rcv_en_reg & tick[2] & (rcv_cnt_reg == 16'h0);
   assign rcv_restart = rcv_serv | rcv_expire | ~rcv_en_reg
                      | (wr_acc & (PADDR == OFS_RCV_CTRL));

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rcv_en_reg   <= 1'b0;
         rcv_load_reg <= RCV_LOAD_RST;
         rcv_cnt_reg  <= RCV_LOAD_RST;
      end
      else
      begin
         if (wr_acc & (PADDR == OFS_RCV_CTRL))
            rcv_en_reg <= PWDATA[0];
         if (wr_acc & (PADDR == OFS_RCV_LOAD))
            rcv_load_reg <= PWDATA[15:0];
         if (rcv_restart)
            rcv_cnt_reg <= rcv_load_reg;
         else if (tick[2])
            rcv_cnt_reg <= rcv_cnt_reg - 16'h1;
      end
   end

   // status, interrupt, reset cause and reset pulse
   logic [ST_W-1:0] status_reg;
   logic [ST_W-1:0] int_en_reg;
   logic [ST_W-1:0] st_set;
   logic [ST_W-1:0] st_clr;
   logic [2:0]      cause_reg;
   logic [2:0]      cause_clr;
   logic            any_expire;
   logic [4:0]      rst_cnt_reg;
   logic            sys_reset_reg;
   logic            irq_reg;

   assign st_set     = {wd_early, rcv_expire, wd_expire};
   assign st_clr     = (wr_acc & (PADDR == OFS_INT_CLR)) ? PWDATA[ST_W-1:0] : '0;
   assign cause_clr  = (wr_acc & (PADDR == OFS_CAUSE)) ? PWDATA[2:0] : 3'h0;
   assign any_expire = |wd_expire | rcv_expire;

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         status_reg    <= '0;
         int_en_reg    <= '0;
         cause_reg     <= 3'h0;
         rst_cnt_reg   <= 5'h0;
         sys_reset_reg <= 1'b0;
         irq_reg       <= 1'b0;
      end
      else
      begin
         // set wins over a clear written in the same cycle
         status_reg <= (status_reg & ~st_clr) | st_set;
         if (wr_acc & (PADDR == OFS_INT_EN))
            int_en_reg <= PWDATA[ST_W-1:0];
         cause_reg <= (cause_reg & ~cause_clr) | {rcv_expire, wd_expire};
         irq_reg   <= |(((status_reg & ~st_clr) | st_set) & int_en_reg);
         // a new expiry restarts the full-length reset pulse
         if (any_expire)
         begin
            sys_reset_reg <= 1'b1;
            rst_cnt_reg   <= RST_PULSE_LAST;
         end
         else if (rst_cnt_reg != 5'h0)
            rst_cnt_reg <= rst_cnt_reg - 5'h1;
         else
            sys_reset_reg <= 1'b0;
      end
   end

   // apb read mux and answer
   always_comb
   begin
      rd_mux = 32'h0;
      // service offsets read back the live count
      if (in_dog)
      begin
         case (dog_sub)
            SUB_CTRL:    rd_mux = 32'(ctrl_reg[dog_idx]);
            SUB_LOAD:    rd_mux = load_reg[dog_idx];
            SUB_WIN:     rd_mux = win_reg[dog_idx];
            default:     rd_mux = cnt_reg[dog_idx];
         endcase
      end
      else
      begin
         case (PADDR)
            OFS_RCV_CTRL: rd_mux = {31'h0, rcv_en_reg};
            OFS_RCV_LOAD: rd_mux = {16'h0, rcv_load_reg};
            OFS_RCV_SERV: rd_mux = {16'h0, rcv_cnt_reg};
            OFS_STATUS:   rd_mux = {27'h0, status_reg};
            OFS_INT_EN:   rd_mux = {27'h0, int_en_reg};
            OFS_CAUSE:    rd_mux = {29'h0, cause_reg};
            default:      rd_mux = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg  <= setup_done;
         pslverr_reg <= setup_done & ~mapped;
         // read data held until the next read
         if (setup_done & ~PWRITE)
            prdata_reg <= rd_mux;
      end
   end

   assign PREADY    = pready_reg;
   assign PRDATA    = prdata_reg;
   assign PSLVERR   = pslverr_reg;
   assign SYS_RESET = sys_reset_reg;
   assign IRQ       = irq_reg;

endmodule // watchdog_top

// File: watchdog_pkg_unused_guard.sv
// intentionally minimal: no further content
`timescale 1ns/1ps

// File: watchdog_checker.sv
// bus and reset-pulse assertions for the watchdog block
`timescale 1ns/1ps
module watchdog_checker
   import watchdog_pkg::*;
(
   input wire logic        CLK_SYS,  // clock
   input wire logic        RST_N,    // reset
   input wire logic        PSEL,     // select
   input wire logic        PENABLE,  // access
   input wire logic        PWRITE,   // direction
   input wire logic [7:0]  PADDR,    // address
   input wire logic [31:0] PRDATA,   // read data
   input wire logic        PREADY,   // ready
   input wire logic        PSLVERR,  // error
   input wire logic        SYS_RESET // reset request
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   wire logic rd_done = PREADY && !PWRITE;
   property p_ready; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
   a_ready: assert property (p_ready) else $error("ready late");
   property p_pulse; PREADY |=> !PREADY; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_err; PSLVERR |-> PREADY; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_bad; PREADY && (PADDR == 8'h2c || PADDR >= 8'h40) |-> PSLVERR; endproperty
   a_bad: assert property (p_bad) else $error("unmapped not refused");
   property p_good; PREADY && PADDR[1:0] == 2'h0 && PADDR < 8'h40 && PADDR != 8'h2c |-> !PSLVERR;
   endproperty
   a_good: assert property (p_good) else $error("mapped refused");
   property p_len; $rose(SYS_RESET) |-> SYS_RESET[*8] ##1 SYS_RESET[*8]; endproperty
   a_len: assert property (p_len) else $error("reset pulse short");
   property p_cause; rd_done && PADDR == OFS_CAUSE |-> PRDATA[31:3] == 29'h0; endproperty
   a_cause: assert property (p_cause) else $error("cause upper bits");
   property p_rcv; rd_done && PADDR == OFS_RCV_LOAD |-> PRDATA[31:16] == 16'h0; endproperty
   a_rcv: assert property (p_rcv) else $error("recovery load width");
   property p_hold; !PREADY |=> PREADY || $stable(PRDATA); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   c_rst: cover property ($rose(SYS_RESET));
   c_err: cover property (PSLVERR);
   c_rd: cover property (rd_done && PADDR == OFS_CAUSE && PRDATA != 32'h0);
endmodule // watchdog_checker
bind watchdog_top watchdog_checker watchdog_checker_i (.CLK_SYS, .RST_N, .PSEL, .PENABLE,
   .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .SYS_RESET);

// File: windowed_and_recovery_watchdogs_test.sv
// self-checking bench for the watchdog block
`timescale 1ns/1ps
module windowed_and_recovery_watchdogs_test
   import watchdog_pkg::*;
;
   logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, sys_reset, irq;
   logic [2:0]  run = 3'h3, div = 3'h0;
   logic        rtc_clk = 0, pmc_clk = 0, ring_clk = 0;
   logic [33:0] note;
   logic [33:0] q[$];
   int          n_mismatch = 0, total_checks = 0, seed = 32'h71e7;
   logic [7:0]  ra[9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h24, 8'h30, 8'h3c};
   logic [31:0] rv[9] = '{32'h0, 32'hffffffff, 32'hffffffff, 32'h0, 32'hffffffff,
                          32'hffffffff, 32'hffff, 32'h0, 32'h0};
   watchdog_top watchdog_top_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .RTC_CLK(rtc_clk), .PMC_CLK(pmc_clk),
      .RING_CLK(ring_clk), .SYS_RESET(sys_reset), .IRQ(irq));
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      div      <= div + 3'h1;
      rtc_clk  <= run[0] & div[1];
      pmc_clk  <= run[1] & div[2];
      ring_clk <= run[2] & div[1];
   end
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      int n;
      q.push_back({w, e});
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         n_mismatch++;
         tally_and_finish;
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 33'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      bus(1'b0, a, 32'h0, {1'b0, ex});
   endtask
   function automatic logic [7:0] da(input logic b, input logic [1:0] s);
      return (b ? OFS_WDB_BASE : OFS_WDA_BASE) + {4'h0, s, 2'h0};
   endfunction
   always @(posedge clk_sys)
      if (pready === 1'b1 && q.size() > 0)
      begin
         note = q.pop_front();
         chk("error flag", {31'h0, note[32]}, {31'h0, pslverr});
         if (!note[33]) chk("read data", note[31:0], prdata);
      end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (ra[i]) rd(ra[i], rv[i]);
      bus(1'b0, 8'h2c, 32'h0, {1'b1, 32'h0});
      bus(1'b1, 8'h40, 32'h1, {1'b1, 32'h0});
      $display("reset values done");
      wr(da(0, SUB_LOAD), 32'h4);
      wr(da(0, SUB_CTRL), 32'h10001);
      repeat (20) wr(da(0, SUB_SERVICE), $random(seed));
      wr(da(0, SUB_CTRL), 32'h0);
      rd(OFS_CAUSE, 32'h0);
      $display("timely service done");
      for (int k = 0; k < 4; k++)
      begin
         wr(da(k[0], SUB_LOAD), 32'h2 + ($random(seed) & 32'h3));
         wr(da(k[0], SUB_CTRL), {28'h0, k[1:0], 2'h1});
         repeat (150) @(posedge clk_sys);
         wr(da(k[0], SUB_CTRL), 32'h0);
         rd(OFS_CAUSE, k == 3 ? 32'h0 : 32'h1 << k[0]);
         rd(OFS_STATUS, k == 3 ? 32'h0 : 32'h1 << k[0]);
         wr(OFS_CAUSE, 32'h7);
         wr(OFS_INT_CLR, 32'h1f);
      end
      $display("clock sources done");
      wr(da(0, SUB_LOAD), 32'h14);
      wr(da(0, SUB_WIN), 32'h5);
      wr(da(0, SUB_CTRL), 32'h3);
      wr(da(0, SUB_SERVICE), $random(seed));
      wr(da(0, SUB_CTRL), 32'h0);
      rd(OFS_STATUS, 32'h9);
      rd(OFS_CAUSE, 32'h1);
      wr(OFS_CAUSE, 32'h7);
      $display("early service done");
      for (int k = 0; k < 3; k++)
      begin
         if (k < 2) wr(OFS_INT_EN, k == 0 ? 32'h2 : 32'h8);
         else wr(OFS_INT_CLR, 32'h1f);
         repeat (3) @(posedge clk_sys);
         chk("irq", {31'h0, k == 1}, {31'h0, irq});
      end
      $display("interrupt done");
      wr(OFS_RCV_LOAD, 32'h2);
      wr(OFS_RCV_CTRL, 32'h1);
      repeat (100) @(posedge clk_sys);
      rd(OFS_CAUSE, 32'h0);
      run[2] <= 1'b1;
      repeat (100) @(posedge clk_sys);
      wr(OFS_RCV_CTRL, 32'h0);
      rd(OFS_CAUSE, 32'h4);
      rd(OFS_STATUS, 32'h4);
      $display("recovery done");
      wr(OFS_CAUSE, 32'h7);
      wr(OFS_INT_CLR, 32'h1f);
      wr(OFS_RCV_LOAD, 32'h10);
      wr(OFS_RCV_CTRL, 32'h1);
      repeat (30) wr(OFS_RCV_SERV, $random(seed));
      wr(OFS_RCV_CTRL, 32'h0);
      rd(OFS_CAUSE, 32'h0);
      rd(OFS_STATUS, 32'h0);
      rd(OFS_RCV_SERV, 32'h10);
      $display("recovery service done");
      wr(da(1, SUB_LOAD), 32'h8);
      wr(da(1, SUB_WIN), 32'h3);
      wr(da(1, SUB_CTRL), 32'h10003);
      repeat (6)
      begin
         repeat (9) @(posedge clk_sys);
         wr(da(1, SUB_SERVICE), $random(seed));
      end
      chk("reset request", 32'h0, {31'h0, sys_reset});
      wr(da(1, SUB_SERVICE), $random(seed));
      @(posedge clk_sys);
      chk("reset request", 32'h1, {31'h0, sys_reset});
      wr(da(1, SUB_CTRL), 32'h0);
      rd(OFS_STATUS, 32'h12);
      rd(OFS_CAUSE, 32'h2);
      rd(da(1, SUB_SERVICE), 32'h8);
      $display("window service done");
      tally_and_finish;
   end
   initial
   begin
      repeat (6000) @(posedge clk_sys);
      n_mismatch++;
      tally_and_finish;
   end
endmodule // windowed_and_recovery_watchdogs_test
